// ===== src/alu_defs.svh
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define OFS_ACCUM            8'h00
`define OFS_SOURCE_REGISTER  8'h04
`define OFS_COMMAND          8'h08
`define OFS_FLAG_REGISTER    8'h0c
`define OFS_STATUS           8'h10

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CMD_OP_MSB           4
`define CMD_WORD_BIT         8
`define CMD_IMM_BIT          9
`define FLAG_C_BIT           0
`define FLAG_V_BIT           1
`define FLAG_Z_BIT           2
`define FLAG_N_BIT           3
`define FLAG_H_BIT           5
`define STAT_BUSY_BIT        0
`define STAT_ILLEGAL_BIT     1

// ------------------------------------------------------------
// reset values and timing counts
// ------------------------------------------------------------
`define RST_WORD16           16'h0000
`define RST_COMMAND          10'h000
`define RST_FLAG             1'b0
`define DIV_LAST_STEP        4'hf

`endif

// ===== src/alu_pkg.sv
package alu_pkg;

	typedef enum logic [4:0] {
		OP_SUM                     = 5'h00,
		OP_DIFFERENCE              = 5'h01,
		OP_SUM_WITH_CARRY          = 5'h02,
		OP_DIFFERENCE_WITH_BORROW  = 5'h03,
		OP_COUNT_UP_BY_ONE         = 5'h04,
		OP_COUNT_DOWN_BY_ONE       = 5'h05,
		OP_POINTER_STEP_UP         = 5'h06,
		OP_POINTER_STEP_DOWN       = 5'h07,
		OP_BCD_FIXUP_AFTER_SUM     = 5'h08,
		OP_BCD_FIXUP_AFTER_DIFF    = 5'h09,
		OP_UNSIGNED_BYTE_PRODUCT   = 5'h0a,
		OP_UNSIGNED_WORD_QUOTIENT  = 5'h0b,
		OP_COMPARE_FLAGS_ONLY      = 5'h0c,
		OP_NEGATE                  = 5'h0d,
		OP_AND                     = 5'h0e,
		OP_OR                      = 5'h0f,
		OP_XOR                     = 5'h10,
		OP_INVERT                  = 5'h11,
		OP_ARITH_LEFT_SHIFT        = 5'h12,
		OP_ARITH_RIGHT_SHIFT       = 5'h13,
		OP_LOGIC_LEFT_SHIFT        = 5'h14,
		OP_LOGIC_RIGHT_SHIFT       = 5'h15,
		OP_CIRCULAR_LEFT           = 5'h16,
		OP_CIRCULAR_RIGHT          = 5'h17,
		OP_CARRY_CIRCULAR_LEFT     = 5'h18,
		OP_CARRY_CIRCULAR_RIGHT    = 5'h19
	} op_t;

	typedef enum logic [1:0] {
		PH_IDLE   = 2'b00,
		PH_DIVIDE = 2'b01,
		PH_FINISH = 2'b11
	} phase_t;

	typedef struct packed {
		logic [15:0] accum;
		logic [15:0] source;
		logic [9:0]  command;
		logic        fn;
		logic        fz;
		logic        fv;
		logic        fc;
		logic        fh;
		logic        illegal;
		phase_t      phase;
		logic [3:0]  step;
		logic [7:0]  rem;
		logic [15:0] quot;
		logic [7:0]  divisor;
		logic [31:0] rdata;
		logic        err;
	} core_state_t;

endpackage : alu_pkg

// ===== src/byte_word_alu_shifter.sv
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`include "alu_defs.svh"

module byte_word_alu_shifter (
	input  wire logic        CORE_CLK_IN,
	input  wire logic        RSTN_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	input  wire logic [3:0]  PSTRB_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	output logic             BUSY_OUT
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// returns {v, h, c, sum}
	function automatic logic [10:0] add_byte(input logic [7:0] a, input logic [7:0] b,
		input logic ci);
		logic [8:0] s;
		logic [4:0] lo;
		s  = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		add_byte = {(a[7] == b[7]) && (s[7] != a[7]), lo[4], s[8], s[7:0]};
	endfunction : add_byte

	// returns {v, h, c, sum}; half carry out of bit 11
	function automatic logic [18:0] add_word(input logic [15:0] a, input logic [15:0] b,
		input logic ci);
		logic [16:0] s;
		logic [12:0] lo;
		s  = {1'b0, a} + {1'b0, b} + {16'h0000, ci};
		lo = {1'b0, a[11:0]} + {1'b0, b[11:0]} + {12'h000, ci};
		add_word = {(a[15] == b[15]) && (s[15] != a[15]), lo[12], s[16], s[15:0]};
	endfunction : add_word

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		merge16 = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
	endfunction : merge16

	function automatic logic op_legal(input alu_pkg::op_t op, input logic word,
		input logic imm, input logic [15:0] src);
		case (op)
			alu_pkg::OP_SUM:                    op_legal = !(word && imm);
			alu_pkg::OP_DIFFERENCE:             op_legal = !imm;
			alu_pkg::OP_COMPARE_FLAGS_ONLY:     op_legal = !(word && imm);
			alu_pkg::OP_SUM_WITH_CARRY,
			alu_pkg::OP_DIFFERENCE_WITH_BORROW,
			alu_pkg::OP_AND,
			alu_pkg::OP_OR,
			alu_pkg::OP_XOR:                    op_legal = !word;
			alu_pkg::OP_POINTER_STEP_UP,
			alu_pkg::OP_POINTER_STEP_DOWN:      op_legal = word && imm &&
				(src == 16'h0001 || src == 16'h0002);
			alu_pkg::OP_COUNT_UP_BY_ONE,
			alu_pkg::OP_COUNT_DOWN_BY_ONE,
			alu_pkg::OP_BCD_FIXUP_AFTER_SUM,
			alu_pkg::OP_BCD_FIXUP_AFTER_DIFF,
			alu_pkg::OP_UNSIGNED_BYTE_PRODUCT,
			alu_pkg::OP_UNSIGNED_WORD_QUOTIENT,
			alu_pkg::OP_NEGATE,
			alu_pkg::OP_INVERT,
			alu_pkg::OP_ARITH_LEFT_SHIFT,
			alu_pkg::OP_ARITH_RIGHT_SHIFT,
			alu_pkg::OP_LOGIC_LEFT_SHIFT,
			alu_pkg::OP_LOGIC_RIGHT_SHIFT,
			alu_pkg::OP_CIRCULAR_LEFT,
			alu_pkg::OP_CIRCULAR_RIGHT,
			alu_pkg::OP_CARRY_CIRCULAR_LEFT,
			alu_pkg::OP_CARRY_CIRCULAR_RIGHT:   op_legal = !word && !imm;
			default:                            op_legal = 1'b0;
		endcase
	endfunction : op_legal

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	alu_pkg::core_state_t st;
	alu_pkg::core_state_t next_st;

	always_comb begin
		logic        access_wr;
		logic        busy;
		logic        mapped;
		logic [7:0]  a8;
		logic [7:0]  b8;
		logic [7:0]  r8;
		logic [7:0]  adj;
		logic [8:0]  part;
		logic        ge;
		logic [10:0] s8;
		logic [18:0] s16;
		logic        word;
		logic        imm;
		alu_pkg::op_t op;
		next_st   = st;
		busy      = (st.phase != alu_pkg::PH_IDLE);
		access_wr = PSEL_IN && PENABLE_IN && PWRITE_IN && !st.err;
		mapped    = (PADDR_IN == `OFS_ACCUM) || (PADDR_IN == `OFS_SOURCE_REGISTER) ||
			(PADDR_IN == `OFS_COMMAND) || (PADDR_IN == `OFS_FLAG_REGISTER) ||
			(PADDR_IN == `OFS_STATUS);
		a8   = st.accum[7:0];
		b8   = st.source[7:0];
		r8   = 8'h00;
		adj  = 8'h00;
		part = 9'h000;
		ge   = 1'b0;
		s8   = 11'h000;
		s16  = 19'h00000;
		word = PWDATA_IN[`CMD_WORD_BIT];
		imm  = PWDATA_IN[`CMD_IMM_BIT];
		op   = alu_pkg::op_t'(PWDATA_IN[`CMD_OP_MSB:0]);

		// ------------------------------------------------------------
		// apb setup: capture read data and error one cycle early
		// ------------------------------------------------------------
		if (PSEL_IN && !PENABLE_IN) begin
			// writes other than to status are refused while a divide runs
			next_st.err = !mapped || (PWRITE_IN && busy && PADDR_IN != `OFS_STATUS);
			case (PADDR_IN)
				`OFS_ACCUM:           next_st.rdata = {16'h0000, st.accum};
				`OFS_SOURCE_REGISTER: next_st.rdata = {16'h0000, st.source};
				`OFS_COMMAND:         next_st.rdata = {22'h000000, st.command};
				`OFS_FLAG_REGISTER:   next_st.rdata = {26'h0000000, st.fh, 1'b0, st.fn,
					st.fz, st.fv, st.fc};
				`OFS_STATUS:          next_st.rdata = {30'h00000000, st.illegal, busy};
				default:              next_st.rdata = 32'h00000000;
			endcase
		end

		// ------------------------------------------------------------
		// iterative divide, one quotient bit per cycle
		// ------------------------------------------------------------
		case (st.phase)
			alu_pkg::PH_DIVIDE: begin
				part = {st.rem, st.quot[15]};
				ge   = (part >= {1'b0, st.divisor});
				next_st.rem  = ge ? 8'(part - {1'b0, st.divisor}) : part[7:0];
				next_st.quot = {st.quot[14:0], ge};
				next_st.step = 4'(st.step + 4'h1);
				if (st.step == `DIV_LAST_STEP) begin
					next_st.phase = alu_pkg::PH_FINISH;
				end
			end
			alu_pkg::PH_FINISH: begin
				// quotient wider than a byte is truncated; caller keeps dividend in range
				next_st.accum = {st.rem, st.quot[7:0]};
				next_st.fn    = st.divisor[7];
				next_st.fz    = 1'b0;
				next_st.phase = alu_pkg::PH_IDLE;
			end
			default: begin
				next_st.phase = alu_pkg::PH_IDLE;
			end
		endcase

		// ------------------------------------------------------------
		// register writes
		// ------------------------------------------------------------
		if (access_wr) begin
			case (PADDR_IN)
				`OFS_ACCUM:           next_st.accum  = merge16(st.accum, PWDATA_IN, PSTRB_IN);
				`OFS_SOURCE_REGISTER: next_st.source = merge16(st.source, PWDATA_IN, PSTRB_IN);
				`OFS_FLAG_REGISTER: begin
					if (PSTRB_IN[0]) begin
						next_st.fc = PWDATA_IN[`FLAG_C_BIT];
						next_st.fv = PWDATA_IN[`FLAG_V_BIT];
						next_st.fz = PWDATA_IN[`FLAG_Z_BIT];
						next_st.fn = PWDATA_IN[`FLAG_N_BIT];
						next_st.fh = PWDATA_IN[`FLAG_H_BIT];
					end
				end
				`OFS_STATUS: begin
					if (PSTRB_IN[0] && PWDATA_IN[`STAT_ILLEGAL_BIT]) begin
						next_st.illegal = 1'b0;
					end
				end
				`OFS_COMMAND: begin
					next_st.command = PWDATA_IN[9:0];
					if (!op_legal(op, word, imm, st.source)) begin
						next_st.illegal = 1'b1;
					end else begin
						case (op)
							alu_pkg::OP_SUM,
							alu_pkg::OP_DIFFERENCE,
							alu_pkg::OP_COMPARE_FLAGS_ONLY: begin
								if (word) begin
									if (op == alu_pkg::OP_SUM) begin
										s16 = add_word(st.accum, st.source, 1'b0);
										next_st.fc = s16[16];
										next_st.fh = s16[17];
									end else begin
										s16 = add_word(st.accum, ~st.source, 1'b1);
										next_st.fc = !s16[16];
										next_st.fh = !s16[17];
									end
									next_st.fv = s16[18];
									next_st.fn = s16[15];
									next_st.fz = (s16[15:0] == 16'h0000);
									if (op != alu_pkg::OP_COMPARE_FLAGS_ONLY) begin
										next_st.accum = s16[15:0];
									end
								end else begin
									if (op == alu_pkg::OP_SUM) begin
										s8 = add_byte(a8, b8, 1'b0);
										next_st.fc = s8[8];
										next_st.fh = s8[9];
									end else begin
										s8 = add_byte(a8, ~b8, 1'b1);
										next_st.fc = !s8[8];
										next_st.fh = !s8[9];
									end
									next_st.fv = s8[10];
									next_st.fn = s8[7];
									next_st.fz = (s8[7:0] == 8'h00);
									if (op != alu_pkg::OP_COMPARE_FLAGS_ONLY) begin
										next_st.accum[7:0] = s8[7:0];
									end
								end
							end
							alu_pkg::OP_SUM_WITH_CARRY,
							alu_pkg::OP_DIFFERENCE_WITH_BORROW,
							alu_pkg::OP_NEGATE,
							alu_pkg::OP_COUNT_UP_BY_ONE,
							alu_pkg::OP_COUNT_DOWN_BY_ONE: begin
								case (op)
									alu_pkg::OP_SUM_WITH_CARRY:
										s8 = add_byte(a8, b8, st.fc);
									alu_pkg::OP_DIFFERENCE_WITH_BORROW:
										s8 = add_byte(a8, ~b8, !st.fc);
									alu_pkg::OP_NEGATE:
										s8 = add_byte(8'h00, ~a8, 1'b1);
									alu_pkg::OP_COUNT_UP_BY_ONE:
										s8 = add_byte(a8, 8'h00, 1'b1);
									default:
										s8 = add_byte(a8, 8'hff, 1'b0);
								endcase
								if (op == alu_pkg::OP_SUM_WITH_CARRY) begin
									next_st.fc = s8[8];
									next_st.fh = s8[9];
								end else if (op == alu_pkg::OP_DIFFERENCE_WITH_BORROW ||
									op == alu_pkg::OP_NEGATE) begin
									next_st.fc = !s8[8];
									next_st.fh = !s8[9];
								end
								next_st.fv = s8[10];
								next_st.fn = s8[7];
								next_st.fz = (s8[7:0] == 8'h00);
								next_st.accum[7:0] = s8[7:0];
							end
							alu_pkg::OP_POINTER_STEP_UP: begin
								// flags untouched so address stepping keeps conditions
								next_st.accum = 16'(st.accum + st.source);
							end
							alu_pkg::OP_POINTER_STEP_DOWN: begin
								next_st.accum = 16'(st.accum - st.source);
							end
							alu_pkg::OP_BCD_FIXUP_AFTER_SUM: begin
								next_st.fc = st.fc;
								if (st.fc || a8 > 8'h99) begin
									adj = adj | 8'h60;
									next_st.fc = 1'b1;
								end
								if (st.fh || a8[3:0] > 4'h9) begin
									adj = adj | 8'h06;
								end
								r8 = 8'(a8 + adj);
								next_st.fn = r8[7];
								next_st.fz = (r8 == 8'h00);
								next_st.accum[7:0] = r8;
							end
							alu_pkg::OP_BCD_FIXUP_AFTER_DIFF: begin
								adj = (st.fc ? 8'h60 : 8'h00) | (st.fh ? 8'h06 : 8'h00);
								r8 = 8'(a8 - adj);
								next_st.fn = r8[7];
								next_st.fz = (r8 == 8'h00);
								next_st.accum[7:0] = r8;
							end
							alu_pkg::OP_UNSIGNED_BYTE_PRODUCT: begin
								// widen before multiplying so the upper product byte survives
								next_st.accum = {8'h00, a8} * {8'h00, b8};
							end
							alu_pkg::OP_UNSIGNED_WORD_QUOTIENT: begin
								if (b8 == 8'h00) begin
									// divide by zero: destination kept, zero flag raised
									next_st.fz = 1'b1;
									next_st.fn = 1'b0;
								end else begin
									next_st.phase   = alu_pkg::PH_DIVIDE;
									next_st.step    = 4'h0;
									next_st.rem     = 8'h00;
									next_st.quot    = st.accum;
									next_st.divisor = b8;
								end
							end
							default: begin
								case (op)
									alu_pkg::OP_AND:    r8 = a8 & b8;
									alu_pkg::OP_OR:     r8 = a8 | b8;
									alu_pkg::OP_XOR:    r8 = a8 ^ b8;
									alu_pkg::OP_INVERT: r8 = ~a8;
									alu_pkg::OP_ARITH_LEFT_SHIFT,
									alu_pkg::OP_LOGIC_LEFT_SHIFT:
										r8 = {a8[6:0], 1'b0};
									alu_pkg::OP_ARITH_RIGHT_SHIFT:
										r8 = {a8[7], a8[7:1]};
									alu_pkg::OP_LOGIC_RIGHT_SHIFT:
										r8 = {1'b0, a8[7:1]};
									alu_pkg::OP_CIRCULAR_LEFT:
										r8 = {a8[6:0], a8[7]};
									alu_pkg::OP_CIRCULAR_RIGHT:
										r8 = {a8[0], a8[7:1]};
									alu_pkg::OP_CARRY_CIRCULAR_LEFT:
										r8 = {a8[6:0], st.fc};
									default:
										r8 = {st.fc, a8[7:1]};
								endcase
								next_st.fv = 1'b0;
								if (op == alu_pkg::OP_ARITH_LEFT_SHIFT) begin
									next_st.fv = a8[7] ^ a8[6];
								end
								case (op)
									alu_pkg::OP_ARITH_LEFT_SHIFT,
									alu_pkg::OP_LOGIC_LEFT_SHIFT,
									alu_pkg::OP_CIRCULAR_LEFT,
									alu_pkg::OP_CARRY_CIRCULAR_LEFT:
										next_st.fc = a8[7];
									alu_pkg::OP_ARITH_RIGHT_SHIFT,
									alu_pkg::OP_LOGIC_RIGHT_SHIFT,
									alu_pkg::OP_CIRCULAR_RIGHT,
									alu_pkg::OP_CARRY_CIRCULAR_RIGHT:
										next_st.fc = a8[0];
									default:
										next_st.fc = st.fc;
								endcase
								next_st.fn = r8[7];
								next_st.fz = (r8 == 8'h00);
								next_st.accum[7:0] = r8;
							end
						endcase
					end
				end
				default: begin
					next_st.err = st.err;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			st.accum   <= `RST_WORD16;
			st.source  <= `RST_WORD16;
			st.command <= `RST_COMMAND;
			st.fn      <= `RST_FLAG;
			st.fz      <= `RST_FLAG;
			st.fv      <= `RST_FLAG;
			st.fc      <= `RST_FLAG;
			st.fh      <= `RST_FLAG;
			st.illegal <= 1'b0;
			st.phase   <= alu_pkg::PH_IDLE;
			st.step    <= 4'h0;
			st.rem     <= 8'h00;
			st.quot    <= 16'h0000;
			st.divisor <= 8'h00;
			st.rdata   <= 32'h00000000;
			st.err     <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// one wait-free access: data was latched in the setup cycle
	assign PREADY_OUT  = PSEL_IN && PENABLE_IN;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && st.err;
	assign PRDATA_OUT  = st.rdata;
	assign BUSY_OUT    = (st.phase != alu_pkg::PH_IDLE);

endmodule : byte_word_alu_shifter

// ===== bench/byte_word_alu_shifter_asserts.sv
`timescale 1ns/1ps
module byte_word_alu_shifter_asserts (
	input wire logic        CORE_CLK_IN,
	input wire logic        RSTN_IN,
	input wire logic        PSEL_IN,
	input wire logic        PENABLE_IN,
	input wire logic        PWRITE_IN,
	input wire logic [7:0]  PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic [3:0]  PSTRB_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic        PREADY_OUT,
	input wire logic        PSLVERR_OUT,
	input wire logic        BUSY_OUT
);
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!RSTN_IN);

	logic mapped;
	logic div_wr;
	assign mapped = PADDR_IN inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
	assign div_wr = PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == 8'h08
		&& PWDATA_IN[4:0] == 5'h0b;

	// --------------------------------------------
	// bus phases
	// --------------------------------------------
	sequence s_setup(logic [7:0] a, logic w);
		PSEL_IN && !PENABLE_IN && PADDR_IN == a && PWRITE_IN == w;
	endsequence
	sequence s_access;
		PSEL_IN && PENABLE_IN;
	endsequence
	// 16 divide steps plus the finish cycle
	sequence s_busy_run;
		BUSY_OUT[*8] ##1 BUSY_OUT[*8] ##1 BUSY_OUT;
	endsequence

	property p_ready;
		s_access |-> PREADY_OUT;
	endproperty
	property p_idle;
		!PSEL_IN |-> !PREADY_OUT && !PSLVERR_OUT;
	endproperty
	property p_unmapped;
		PSEL_IN && !PENABLE_IN && !mapped ##1 s_access
			|-> PSLVERR_OUT && (PWRITE_IN || PRDATA_OUT == 32'h0);
	endproperty
	property p_busy_refuse;
		BUSY_OUT && PSEL_IN && !PENABLE_IN && PWRITE_IN && PADDR_IN != 8'h10 ##1 s_access
			|-> PSLVERR_OUT;
	endproperty
	property p_busy_len;
		$rose(BUSY_OUT) |-> s_busy_run ##1 !BUSY_OUT;
	endproperty
	property p_busy_cause;
		$rose(BUSY_OUT) |-> $past(div_wr);
	endproperty
	property p_accum_read;
		s_setup(8'h00, 1'b0) ##1 s_access |-> PRDATA_OUT[31:16] == 16'h0;
	endproperty
	property p_flag_read;
		s_setup(8'h0c, 1'b0) ##1 s_access |-> PRDATA_OUT[31:6] == 26'h0 && !PRDATA_OUT[4];
	endproperty

	a_ready: assert property (p_ready)
		else $error("ready missing in access cycle");
	a_idle: assert property (p_idle)
		else $error("ready or error without select");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not refused");
	a_busy_refuse: assert property (p_busy_refuse)
		else $error("write accepted during divide");
	a_busy_len: assert property (p_busy_len)
		else $error("divide busy span wrong");
	a_busy_cause: assert property (p_busy_cause)
		else $error("busy without divide command");
	a_accum_read: assert property (p_accum_read)
		else $error("accumulator upper half not zero");
	a_flag_read: assert property (p_flag_read)
		else $error("flag register reserved bits set");
endmodule : byte_word_alu_shifter_asserts

bind byte_word_alu_shifter byte_word_alu_shifter_asserts u_byte_word_alu_shifter_asserts (
	.CORE_CLK_IN(CORE_CLK_IN),
	.RSTN_IN    (RSTN_IN),
	.PSEL_IN    (PSEL_IN),
	.PENABLE_IN (PENABLE_IN),
	.PWRITE_IN  (PWRITE_IN),
	.PADDR_IN   (PADDR_IN),
	.PWDATA_IN  (PWDATA_IN),
	.PSTRB_IN   (PSTRB_IN),
	.PRDATA_OUT (PRDATA_OUT),
	.PREADY_OUT (PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT),
	.BUSY_OUT   (BUSY_OUT)
);

// ===== bench/apb_requester.sv
`timescale 1ns/1ps
module apb_requester (
	input  wire logic        clk_in,
	output logic             psel_out,
	output logic             penable_out,
	output logic             pwrite_out,
	output logic [7:0]       paddr_out,
	output logic [31:0]      pwdata_out,
	output logic [3:0]       pstrb_out,
	input  wire logic [31:0] prdata_in,
	input  wire logic        pready_in,
	input  wire logic        pslverr_in
);
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 8'h00;
		pwdata_out = 32'h0;
		pstrb_out = 4'h0;
	end

	// --------------------------------------------
	// one transfer, held until ready is sampled
	// --------------------------------------------
	task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk_in);
		psel_out <= 1'b1;
		penable_out <= 1'b0;
		pwrite_out <= wr;
		paddr_out <= a;
		pwdata_out <= d;
		pstrb_out <= 4'hf;
		@(posedge clk_in);
		penable_out <= 1'b1;
		n = 0;
		@(posedge clk_in);
		while (pready_in !== 1'b1 && n < 64) begin
			@(posedge clk_in);
			n++;
		end
		rd = prdata_in;
		err = pslverr_in;
		if (n >= 64) begin
			// a slave that never answers shows as unknown so every compare trips
			rd = 32'hxxxxxxxx;
			err = 1'bx;
		end
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		// stale values would hide a slave that samples too late
		paddr_out <= ~a;
		pwdata_out <= ~d;
	endtask : bus_xfer
endmodule : apb_requester

// ===== bench/byte_word_alu_shifter_tb.sv
`timescale 1ns/1ps
module byte_word_alu_shifter_tb;
	logic        clk;
	logic        rstn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        busy;
	logic [31:0] rd;
	int          n_mismatch;
	int          checks_done;
	logic [7:0]  sh_exp [16] = '{8'h02, 8'hc0, 8'h02, 8'h40, 8'h03, 8'hc0, 8'h03, 8'hc0,
		8'h84, 8'h21, 8'h84, 8'h21, 8'h84, 8'h21, 8'h85, 8'ha1};

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	byte_word_alu_shifter u_byte_word_alu_shifter (
		.CORE_CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .BUSY_OUT(busy));

	apb_requester u_apb_requester (
		.clk_in(clk), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
		.paddr_out(paddr), .pwdata_out(pwdata), .pstrb_out(pstrb),
		.prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));

	// --------------------------------------------
	// access and compare tasks
	// --------------------------------------------
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic eerr, output logic [31:0] r);
		logic err;
		u_apb_requester.bus_xfer(w, a, d, r, err);
		check("slave error", {31'h0, eerr}, {31'h0, err});
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, 1'b0, r);
	endtask : wr

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, 1'b0, r);
		check(name, exp, r);
	endtask : rd_chk

	// wi is {immediate, word}; ec of x skips the carry check
	task automatic run(input logic [4:0] op, input logic [1:0] wi, input logic [15:0] a,
		input logic [15:0] s, input logic [7:0] fin, input logic [15:0] eacc, input logic ec);
		logic [31:0] r;
		int n;
		wr(8'h00, {16'h0, a});
		wr(8'h04, {16'h0, s});
		wr(8'h0c, {24'h0, fin});
		wr(8'h08, {22'h0, wi, 3'h0, op});
		n = 0;
		@(negedge clk);
		while (busy !== 1'b0 && n < 40) begin
			@(negedge clk);
			n++;
		end
		check("busy", 32'h0, {31'h0, busy});
		rd_chk("accumulator", 8'h00, {16'h0, eacc});
		if (ec !== 1'bx) begin
			xfer(1'b0, 8'h0c, 32'h0, 1'b0, r);
			check("carry flag", {31'h0, ec}, {31'h0, r[0]});
		end
	endtask : run

	task automatic ill(input logic [4:0] op, input logic [1:0] wi, input logic [15:0] s);
		run(op, wi, 16'h0077, s, 8'h00, 16'h0077, 1'bx);
		rd_chk("illegal flag", 8'h10, 32'h2);
		wr(8'h10, 32'h2);
		rd_chk("illegal flag", 8'h10, 32'h0);
	endtask : ill

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test

	// --------------------------------------------
	// tests
	// --------------------------------------------
	initial begin
		rstn = 1'b0;
		n_mismatch = 0;
		checks_done = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd_chk("accumulator", 8'h00, 32'h0);
		rd_chk("flags", 8'h0c, 32'h0);
		rd_chk("status", 8'h10, 32'h0);
		$display("test reset done");
		run(5'h00, 2'b00, 16'h12f0, 16'h0020, 8'h00, 16'h1210, 1'b1);
		run(5'h00, 2'b01, 16'h8000, 16'h8001, 8'h00, 16'h0001, 1'b1);
		run(5'h01, 2'b01, 16'h0100, 16'h0001, 8'h00, 16'h00ff, 1'b0);
		run(5'h01, 2'b00, 16'h0010, 16'h0020, 8'h00, 16'h00f0, 1'b1);
		run(5'h00, 2'b10, 16'h0005, 16'h0003, 8'h00, 16'h0008, 1'b0);
		ill(5'h01, 2'b10, 16'h0003);
		ill(5'h00, 2'b11, 16'h0003);
		run(5'h02, 2'b00, 16'h00fe, 16'h0001, 8'h01, 16'h0000, 1'b1);
		run(5'h03, 2'b10, 16'h0005, 16'h0003, 8'h01, 16'h0001, 1'b0);
		run(5'h04, 2'b00, 16'h00ff, 16'h0000, 8'h01, 16'h0000, 1'b1);
		run(5'h05, 2'b00, 16'h3400, 16'h0000, 8'h00, 16'h34ff, 1'b0);
		run(5'h06, 2'b11, 16'hffff, 16'h0002, 8'h01, 16'h0001, 1'b1);
		run(5'h07, 2'b11, 16'h0000, 16'h0001, 8'h00, 16'hffff, 1'b0);
		ill(5'h06, 2'b11, 16'h0003);
		run(5'h08, 2'b00, 16'h009a, 16'h0000, 8'h00, 16'h0000, 1'b1);
		run(5'h09, 2'b00, 16'h000f, 16'h0000, 8'h20, 16'h0009, 1'b0);
		run(5'h0a, 2'b00, 16'h00ff, 16'h00ff, 8'h01, 16'hfe01, 1'b1);
		run(5'h0b, 2'b00, 16'h0123, 16'h0010, 8'h00, 16'h0312, 1'bx);
		run(5'h0b, 2'b00, 16'h0123, 16'h0000, 8'h00, 16'h0123, 1'bx);
		run(5'h0c, 2'b00, 16'h0005, 16'h0007, 8'h00, 16'h0005, 1'b1);
		rd_chk("flags", 8'h0c, 32'h29);
		run(5'h0c, 2'b01, 16'h1000, 16'h0001, 8'h00, 16'h1000, 1'b0);
		ill(5'h0c, 2'b11, 16'h0001);
		run(5'h0d, 2'b00, 16'h0001, 16'h0000, 8'h00, 16'h00ff, 1'b1);
		$display("test arithmetic done");
		run(5'h0e, 2'b00, 16'h00f0, 16'h003c, 8'h01, 16'h0030, 1'b1);
		run(5'h0f, 2'b10, 16'h00f0, 16'h003c, 8'h01, 16'h00fc, 1'b1);
		run(5'h10, 2'b00, 16'h00f0, 16'h003c, 8'h01, 16'h00cc, 1'b1);
		run(5'h11, 2'b00, 16'hab55, 16'h0000, 8'h00, 16'habaa, 1'b0);
		ill(5'h0e, 2'b01, 16'h0001);
		$display("test logic done");
		for (int i = 0; i < 16; i++) begin
			run(5'(5'h12 + i % 8), 2'b00, (i < 8) ? 16'h0081 : 16'h0042, 16'h0000, 8'h01,
				{8'h00, sh_exp[i]}, (i < 8));
		end
		$display("test shift done");
		wr(8'h00, 32'h0123);
		wr(8'h04, 32'h0010);
		wr(8'h08, 32'h000b);
		xfer(1'b1, 8'h00, 32'h5555, 1'b1, rd);
		xfer(1'b0, 8'h14, 32'h0, 1'b1, rd);
		check("unmapped read", 32'h0, rd);
		// let the divide finish, else the next writes are refused
		repeat (20) @(posedge clk);
		rd_chk("accumulator", 8'h00, 32'h0312);
		run(5'h0b, 2'b00, 16'h0123, 16'h0010, 8'h00, 16'h0312, 1'bx);
		$display("test refusal done");
		finish_test();
	end

	initial begin
		#100us;
		n_mismatch++;
		finish_test();
	end
endmodule : byte_word_alu_shifter_tb
